/* File: hw/adc_dmic_volume_control.sv */
// ------------------------------------------------------------
// adc_dmic_volume_control: record channel power, source and volume
// ------------------------------------------------------------
// holds the three page-0 control registers and the record sample path.
// assumes the serial control bus decodes into regAddr and the strobes on mclk.
// What this block does
// RULE1 - channel stays powered down until its power bit is set; resets off
// RULE2 - source field 00 takes mic from pin one, 10 from data-in pin
// RULE3 - mic enable set takes samples from the selected mic input
// RULE4 - stepping: 00 every sample, 01 every two samples, 10 immediate
// RULE5 - mute bit silences output; resets to muted
// RULE6 - fine gain attenuates 0.1 dB per code, up to -0.4 dB
// RULE7 - coarse gain two's complement 0.5 dB steps, -12 to +20 dB
// RULE8 - software writes zeros to fine register low four bits
// RULE9 - software writes reset values to reserved registers after coarse gain
// RULE10 - stepping approaches target one 0.5 dB step from a sample boundary
`timescale 1ns/1ps
module adc_dmic_volume_control (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [6:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic generalPurposePinOne,
    input wire logic dataInPin,
    input wire logic signed [15:0] afeSample,
    output logic signed [15:0] recSample,
    output logic recValid,
    output adc_vol_pkg::gain_t recGain,
    output logic recMuted,
    output logic recPowered,
    output logic micActive
);
    import adc_vol_pkg::*;

    // ------------------------------------------------------------
    // gain mapping
    // ------------------------------------------------------------
    // combined gain in tenths of a dB; reserved codes clamp to the nearest end
    function automatic gain_t targetGain(input logic [6:0] coarse, input logic [2:0] fine);
        gain_t c;
        gain_t f;
        c = gain_t'(signed'(coarse)); // see RULE7
        if (c < COARSE_MIN) begin
            c = COARSE_MIN;
        end
        if (c > COARSE_MAX) begin
            c = COARSE_MAX;
        end
        f = gain_t'({7'h00, fine}); // see RULE6
        if (f > FINE_MAX) begin
            f = FINE_MAX;
        end
        return gain_t'(c * GAIN_STEP) - f;
    endfunction

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] muteFine_q, muteFine_d;
    logic [7:0] coarse_q, coarse_d;
    logic [7:0] rdData_q, rdData_d;

    // writes store whole bytes; reserved bits are kept as written
    always_comb begin
        cfg_d = cfg_q;
        muteFine_d = muteFine_q;
        coarse_d = coarse_q;
        rdData_d = rdData_q;
        if (regWrEn) begin
            if (regAddr == ADDR_INPUT_CFG) begin
                cfg_d = regWrData;
            end else if (regAddr == ADDR_MUTE_FINE) begin
                muteFine_d = regWrData; // see RULE8
            end else if (regAddr == ADDR_COARSE) begin
                coarse_d = regWrData;
            end
        end
        if (regRdEn) begin
            if (regAddr == ADDR_INPUT_CFG) begin
                rdData_d = cfg_q;
            end else if (regAddr == ADDR_MUTE_FINE) begin
                rdData_d = muteFine_q;
            end else if (regAddr == ADDR_COARSE) begin
                rdData_d = coarse_q;
            end else begin
                rdData_d = 8'h00;
            end
        end
    end

    // register file, powered down and muted after reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= RST_INPUT_CFG; // see RULE1
            muteFine_q <= RST_MUTE_FINE; // see RULE5
            coarse_q <= RST_COARSE;
            rdData_q <= 8'h00;
        end else begin
            cfg_q <= cfg_d;
            muteFine_q <= muteFine_d;
            coarse_q <= coarse_d;
            rdData_q <= rdData_d;
        end
    end

    // field decode
    logic powerOn;
    logic [1:0] srcSel;
    logic micEn;
    logic [1:0] stepMode;
    logic muteOn;
    gain_t target;
    assign powerOn = cfg_q[POWER_BIT];
    assign srcSel = cfg_q[SRC_HI:SRC_LO];
    assign micEn = cfg_q[MIC_EN_BIT];
    assign stepMode = cfg_q[STEP_HI:STEP_LO];
    assign muteOn = muteFine_q[MUTE_BIT];
    assign target = targetGain(coarse_q[COARSE_HI:0], muteFine_q[FINE_HI:FINE_LO]);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] gpioSync_q, gpioSync_d;
    logic [1:0] dinSync_q, dinSync_d;

    // two flops per mic pin; only the second stage is read
    always_comb begin
        gpioSync_d = {gpioSync_q[0], generalPurposePinOne};
        dinSync_d = {dinSync_q[0], dataInPin};
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gpioSync_q <= 2'h0;
            dinSync_q <= 2'h0;
        end else begin
            gpioSync_q <= gpioSync_d;
            dinSync_q <= dinSync_d;
        end
    end

    // selected mic bit; reserved codes fall back to pin one
    logic srcBit;
    assign srcBit = (srcSel == SRC_DATA_IN) ? dinSync_q[1] : gpioSync_q[1]; // see RULE2

    // ------------------------------------------------------------
    // sample divider
    // ------------------------------------------------------------
    logic [8:0] divCnt_q, divCnt_d;
    logic sampleTick;
    assign sampleTick = powerOn && (divCnt_q == SAMPLE_DIV - 9'h001);

    // held at zero while powered down, so no sample period runs
    always_comb begin
        divCnt_d = divCnt_q + 9'h001;
        if (!powerOn || sampleTick) begin // see RULE1
            divCnt_d = 9'h000;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= 9'h000;
        end else begin
            divCnt_q <= divCnt_d;
        end
    end

    // ------------------------------------------------------------
    // volume stepping
    // ------------------------------------------------------------
    gain_step_if gsIf ();
    assign gsIf.target = target;
    assign gsIf.rate = stepMode;
    assign gsIf.tick = sampleTick;

    volume_stepper stepper (
        .mclk(mclk),
        .rst_n(rst_n),
        .gs(gsIf.step)
    );

    // ------------------------------------------------------------
    // record sample path
    // ------------------------------------------------------------
    logic signed [15:0] sample_q, sample_d;
    logic valid_q, valid_d;
    logic muted_q, muted_d;

    // one sample per tick, from mic or front end, zeroed by mute
    always_comb begin
        sample_d = sample_q;
        valid_d = sampleTick;
        muted_d = muteOn;
        if (!powerOn) begin
            sample_d = 16'sh0000;
        end else if (sampleTick) begin
            if (muteOn) begin
                sample_d = 16'sh0000; // see RULE5
            end else if (micEn) begin
                sample_d = srcBit ? PDM_HIGH : PDM_LOW; // see RULE3
            end else begin
                sample_d = afeSample;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sample_q <= 16'sh0000;
            valid_q <= 1'b0;
            muted_q <= 1'b1;
        end else begin
            sample_q <= sample_d;
            valid_q <= valid_d;
            muted_q <= muted_d;
        end
    end

    // outputs
    assign regRdData = rdData_q;
    assign recSample = sample_q;
    assign recValid = valid_q;
    assign recMuted = muted_q;
    assign recGain = gsIf.current;
    assign recPowered = powerOn;
    assign micActive = powerOn && micEn;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DOWN_SILENT: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE1
        !powerOn |=> (!recValid && recSample == 16'sh0000))
        else $error("powered-down channel produced a sample");
    AST_UP_TICKS: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE1
        $rose(powerOn) |-> ##[1:420] (recValid || !powerOn))
        else $error("powered channel produced no sample in one period");
    AST_MIC_SOURCE: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE2
        (sampleTick && micEn && !muteOn) |=>
        (recSample == ($past(srcSel == SRC_DATA_IN ? dinSync_q[1] : gpioSync_q[1]) ? PDM_HIGH : PDM_LOW)))
        else $error("mic sample not from the selected pin");
    AST_AFE_SOURCE: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE3
        (sampleTick && !micEn && !muteOn) |=> (recSample == $past(afeSample)))
        else $error("front-end sample not passed with mic disabled");
    AST_MUTE_ZERO: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE5
        (sampleTick && muteOn) |=> (recValid && recSample == 16'sh0000 && recMuted))
        else $error("muted channel passed audio");
    AST_FINE_MAP: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE6
        (coarse_q[COARSE_HI:0] == 7'h00 && muteFine_q[FINE_HI:FINE_LO] == 3'h4) |-> (target == -10'sh004))
        else $error("fine code 100 is not -0.4 dB");
    AST_COARSE_MAP: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE7
        (coarse_q[COARSE_HI:0] == 7'h68 && muteFine_q[FINE_HI:FINE_LO] == 3'h0) |-> (target == -10'sh078))
        else $error("coarse code 1101000 is not -12 dB");
    AST_IMMEDIATE_GAIN: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE4
        (stepMode == STEP_OFF) ##1 (stepMode == STEP_OFF) |-> (recGain == $past(target)))
        else $error("gain not applied at once with stepping off");
endmodule

/* File: hw/adc_vol_pkg.sv */
// ------------------------------------------------------------
// package: constants for the record channel volume control
// ------------------------------------------------------------
// holds register offsets, field positions, reset values, codes and timing.
// assumes a single 20 MHz clock and an 8-bit page-0 register port.
package adc_vol_pkg;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic signed [9:0] gain_t; // gain in tenths of a dB

    // ------------------------------------------------------------
    // register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_INPUT_CFG = 7'h51;
    localparam logic [6:0] ADDR_MUTE_FINE = 7'h52;
    localparam logic [6:0] ADDR_COARSE = 7'h53;
    localparam logic [7:0] RST_INPUT_CFG = 8'h00;
    localparam logic [7:0] RST_MUTE_FINE = 8'h80;
    localparam logic [7:0] RST_COARSE = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POWER_BIT = 7;
    localparam int SRC_HI = 5;
    localparam int SRC_LO = 4;
    localparam int MIC_EN_BIT = 3;
    localparam int STEP_HI = 1;
    localparam int STEP_LO = 0;
    localparam int MUTE_BIT = 7;
    localparam int FINE_HI = 6;
    localparam int FINE_LO = 4;
    localparam int COARSE_HI = 6;

    // ------------------------------------------------------------
    // field codes
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_GPIO = 2'h0;
    localparam logic [1:0] SRC_DATA_IN = 2'h2;
    localparam logic [1:0] STEP_EVERY = 2'h0;
    localparam logic [1:0] STEP_EVERY_TWO = 2'h1;
    localparam logic [1:0] STEP_OFF = 2'h2;

    // ------------------------------------------------------------
    // gain limits in tenths of a dB, coarse limits in 0.5 dB codes
    // ------------------------------------------------------------
    localparam gain_t GAIN_ZERO = 10'sh000;
    localparam gain_t GAIN_STEP = 10'sh005;
    localparam gain_t COARSE_MIN = -10'sh018;
    localparam gain_t COARSE_MAX = 10'sh028;
    localparam gain_t FINE_MAX = 10'sh004;

    // ------------------------------------------------------------
    // sample timing and pdm levels
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int SAMPLE_HZ = 48000;
    localparam logic [8:0] SAMPLE_DIV = 9'(CLK_HZ / SAMPLE_HZ);
    localparam logic signed [15:0] PDM_HIGH = 16'sh7fff;
    localparam logic signed [15:0] PDM_LOW = 16'sh8001;

endpackage

/* File: hw/gain_step_if.sv */
// ------------------------------------------------------------
// interface: target gain and step rate towards the stepper
// ------------------------------------------------------------
// carries target, rate and sample tick one way and the applied gain back.
// assumes both ends run on mclk.
`timescale 1ns/1ps
interface gain_step_if;
    import adc_vol_pkg::*;
    gain_t target;
    gain_t current;
    logic [1:0] rate;
    logic tick;
    modport ctrl (output target, output rate, output tick, input current);
    modport step (input target, input rate, input tick, output current);
endinterface

/* File: hw/volume_stepper.sv */
// ------------------------------------------------------------
// volume_stepper: moves the applied gain towards the target
// ------------------------------------------------------------
// steps in 0.5 dB on sample ticks, or follows at once when stepping is off.
// assumes tick is a one-cycle pulse per sample period.
`timescale 1ns/1ps
module volume_stepper (
    input wire logic mclk,
    input wire logic rst_n,
    gain_step_if.step gs
);
    import adc_vol_pkg::*;

    gain_t cur_q, cur_d;
    logic parity_q, parity_d;
    gain_t diff;

    // next gain: one step per tick or per second tick, else jump
    always_comb begin
        cur_d = cur_q;
        parity_d = parity_q;
        diff = gs.target - cur_q;
        if (gs.rate == STEP_OFF || gs.rate == 2'h3) begin // see RULE4
            cur_d = gs.target;
            parity_d = 1'b0;
        end else if (gs.tick) begin // see RULE10
            parity_d = ~parity_q;
            if (gs.rate == STEP_EVERY || parity_q) begin // see RULE4
                if (diff > GAIN_STEP) begin
                    cur_d = cur_q + GAIN_STEP;
                end else if (diff < -GAIN_STEP) begin
                    cur_d = cur_q - GAIN_STEP;
                end else begin
                    cur_d = gs.target;
                end
            end
        end
    end

    // register the gain, 0 dB after reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= GAIN_ZERO;
            parity_q <= 1'b0;
        end else begin
            cur_q <= cur_d;
            parity_q <= parity_d;
        end
    end

    assign gs.current = cur_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_NO_STEP_BETWEEN_TICKS: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE10
        (!gs.tick && (gs.rate == STEP_EVERY || gs.rate == STEP_EVERY_TWO)) |=> $stable(cur_q))
        else $error("gain moved outside a sample tick");
    AST_STEP_SIZE: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE4
        (gs.tick && gs.rate == STEP_EVERY) |=>
        ((cur_q - $past(cur_q)) <= GAIN_STEP && ($past(cur_q) - cur_q) <= GAIN_STEP))
        else $error("gain step larger than 0.5 dB");
    AST_IMMEDIATE: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE4
        (gs.rate == STEP_OFF) |=> (cur_q == $past(gs.target)))
        else $error("gain not applied at once with stepping off");
endmodule

/* File: verif/mic_source_model.sv */
// ------------------------------------------------------------
// mic_source_model: front end and microphone pins feeding the block
// ------------------------------------------------------------
// gives a fresh random front-end sample each cycle and holds two pdm pin levels.
// assumes the bench commands the pin levels; everything moves at the falling edge.
`timescale 1ns/1ps
module mic_source_model (
    input wire logic mclk,
    input wire logic pinOneLevel,
    input wire logic dataInLevel,
    output logic generalPurposePinOne,
    output logic dataInPin,
    output logic signed [15:0] afeSample
);
    int seed;

    // fixed seed so every run sees the same sample stream
    initial begin
        seed = 69;
        generalPurposePinOne = 1'b0;
        dataInPin = 1'b0;
        afeSample = 16'sh0000;
    end

    // new front-end sample every cycle, pin levels as commanded
    always @(negedge mclk) begin
        afeSample <= 16'($random(seed));
        generalPurposePinOne <= pinOneLevel;
        dataInPin <= dataInLevel;
    end
endmodule

/* File: verif/tb.sv */
// ------------------------------------------------------------
// tb: self-checking bench for the record channel control block
// ------------------------------------------------------------
// drives the register port at the falling edge and checks against a model.
// assumes the partner model supplies front-end samples and mic pin levels.
`timescale 1ns/1ps
module tb;
    import adc_vol_pkg::*;
    logic mclk, rst_n, regWrEn, regRdEn, recValid, recMuted, recPowered, micActive;
    logic generalPurposePinOne, dataInPin, pinOneLevel, dataInLevel;
    logic [6:0] regAddr;
    logic [7:0] regWrData, regRdData, cfg, mf, co;
    logic signed [15:0] afeSample, recSample, lastAfe;
    gain_t recGain;
    int errCount, checkCount, cyc, prevCyc, gm, lastMoved;
    logic [7:0] coarseTab [8] = '{8'h68, 8'h28, 8'h7f, 8'h50, 8'h00, 8'h3f, 8'hc0, 8'h01};

    adc_dmic_volume_control u_adc_dmic_volume_control (
        .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .generalPurposePinOne(generalPurposePinOne), .dataInPin(dataInPin),
        .afeSample(afeSample), .recSample(recSample), .recValid(recValid),
        .recGain(recGain), .recMuted(recMuted), .recPowered(recPowered), .micActive(micActive)
    );

    mic_source_model u_mic_source_model (
        .mclk(mclk), .pinOneLevel(pinOneLevel), .dataInLevel(dataInLevel),
        .generalPurposePinOne(generalPurposePinOne), .dataInPin(dataInPin), .afeSample(afeSample)
    );

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    // combined gain target in tenths of a dB, reserved codes clamped
    function automatic int tgt();
        int c;
        int f;
        c = int'(co[6:0]) - (co[6] ? 128 : 0);
        f = (mf[6:4] > 3'h4) ? 4 : int'(mf[6:4]);
        if (c < -24) c = -24;
        if (c > 40) c = 40;
        return c * 5 - f;
    endfunction

    // one 0.5 dB move towards the target, or the remainder
    function automatic int apr(input int g, input int t);
        if (t > g + 5) return g + 5;
        if (t < g - 5) return g - 5;
        return t;
    endfunction

    // muted gives silence, mic path gives full-scale levels, else front end
    function automatic logic signed [15:0] exp_samp();
        logic micBit;
        micBit = (cfg[5:4] == 2'b10) ? dataInLevel : pinOneLevel;
        if (mf[7]) return 16'sh0000;
        if (cfg[7] && cfg[3]) return micBit ? 16'sh7fff : 16'sh8001;
        return lastAfe;
    endfunction

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic fail(input string msg);
        errCount++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) fail("register read value");
    endtask

    task automatic chk_samp(input logic signed [15:0] got, input logic signed [15:0] exp);
        checkCount++;
        if (got !== exp) fail("recorded sample value");
    endtask

    task automatic chk_gain(input gain_t got, input int exp);
        checkCount++;
        if (got !== gain_t'(exp)) fail("applied gain value");
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) fail("status flag value");
    endtask

    task automatic chk_num(input int got, input int exp);
        checkCount++;
        if (got != exp) fail("cycle or step count");
    endtask

    task automatic close_out();
        if (errCount == 0 && checkCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // soft-step model, mode 01 may start on either tick but must alternate
    task automatic step_gain();
        int s;
        s = apr(gm, tgt());
        if (cfg[0] == 1'b1 && s != gm) begin
            if (recGain !== gain_t'(s)) s = gm;
            if (lastMoved != 2) chk_num(int'(s != gm) + lastMoved, 1);
            lastMoved = int'(s != gm);
        end else begin
            lastMoved = 2;
        end
        gm = s;
        chk_gain(recGain, gm);
    endtask

    // ------------------------------------------------------------
    // bus tasks and monitor
    // ------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic pw;
        pw = cfg[7];
        @(negedge mclk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        if (a == 7'h51) cfg = d;
        if (a == 7'h52) mf = d;
        if (a == 7'h53) co = d;
        @(negedge mclk);
        regWrEn = 1'b0;
        if (a == 7'h51 && d[7] && !pw) prevCyc = cyc;
        if (cfg[1]) gm = tgt();
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge mclk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge mclk);
        regRdEn = 1'b0;
        chk_reg(regRdData, e);
    endtask

    task automatic wait_valid();
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (recValid !== 1'b1 && n < 1000);
        if (n >= 1000) fail("no sample pulse");
    endtask

    task automatic samples(input int k);
        repeat (k) wait_valid();
    endtask

    always @(posedge mclk) begin
        lastAfe = afeSample;
        cyc = cyc + 1;
    end

    // every sample pulse: spacing, content, mute flag and gain stepping
    always @(negedge mclk) begin
        if (rst_n && recValid === 1'b1) begin
            chk_num(cyc - prevCyc, int'(SAMPLE_DIV));
            prevCyc = cyc;
            chk_samp(recSample, exp_samp());
            chk_flag(recMuted, mf[7]);
            if (cfg[1] == 1'b0) step_gain();
        end
    end

    // guard against a hang
    initial begin
        #4000000;
        fail("watchdog expired");
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        regAddr = 7'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
        pinOneLevel = 1'b1;
        dataInLevel = 1'b0;
        cfg = 8'h00;
        mf = 8'h80;
        co = 8'h00;
        gm = 0;
        lastMoved = 2;
        repeat (12) @(negedge mclk);
        chk_flag(recMuted, 1'b1);
        rst_n = 1'b1;
        rd(7'h51, 8'h00);
        rd(7'h52, 8'h80);
        rd(7'h53, 8'h00);
        chk_gain(recGain, 0);
        chk_flag(recPowered, 1'b0);
        repeat (900) @(negedge mclk);
        chk_samp(recSample, 16'sh0000);
        wr(7'h10, 8'h5a);
        rd(7'h10, 8'h00);
        wr(7'h54, 8'h00);
        rd(7'h54, 8'h00);
        wr(7'h52, 8'h00);
        wr(7'h51, 8'h86);
        rd(7'h51, 8'h86);
        chk_flag(recPowered, 1'b1);
        chk_flag(micActive, 1'b0);
        samples(3);
        // immediate mode over boundary and reserved gain codes
        for (int i = 0; i < 8; i++) begin
            wr(7'h53, coarseTab[i]);
            wr(7'h52, {1'b0, 3'(i), 4'h0});
            @(negedge mclk);
            chk_gain(recGain, tgt());
        end
        rd(7'h53, 8'h01);
        rd(7'h52, 8'h70);
        // one step per sample, last step the remainder
        wait_valid();
        wr(7'h51, 8'h80);
        wait_valid();
        wr(7'h53, 8'h02);
        wr(7'h52, 8'h20);
        samples(4);
        // one step per two samples
        wait_valid();
        wr(7'h51, 8'h81);
        wait_valid();
        wr(7'h53, 8'h7a);
        samples(18);
        // every source code at both pin levels
        for (int lv = 0; lv < 2; lv++) begin
            for (int s = 0; s < 4; s++) begin
                wait_valid();
                wr(7'h51, {2'b10, 2'(s), 4'b1010});
                pinOneLevel = ~lv[0];
                dataInLevel = lv[0];
                samples(2);
                chk_flag(micActive, 1'b1);
            end
        end
        wait_valid();
        wr(7'h52, 8'ha0);
        samples(2);
        rd(7'h52, 8'ha0);
        wait_valid();
        wr(7'h51, 8'h00);
        chk_flag(recPowered, 1'b0);
        repeat (900) @(negedge mclk);
        chk_samp(recSample, 16'sh0000);
        close_out();
    end
endmodule
